// *** include/lin_params.svh ***
// constants for the lineariser break-point editor
`ifndef LIN_PARAMS_SVH
`define LIN_PARAMS_SVH
`define LIN_MAX_PTS      17
`define LIN_MIN_PTS      2
`define LIN_CUR_MIN_UA   3800
`define LIN_CUR_MAX_UA   21000
`define LIN_LOOP_LO_UA   4000
`define LIN_LOOP_HI_UA   20000
`define LIN_DEF_DISPLAY_VALUE_FN_LO  0
`define LIN_DEF_DISPLAY_VALUE_FN_HI  100
`define LIN_NUM_DIGITS   5
`endif

// *** include/lin_pkg.sv ***
// types shared by the lineariser break-point editor
package lin_pkg;
	typedef enum logic [2:0] {
		FN_ADD,
		FN_REMOVE,
		FN_CAPTURE,
		FN_CUR_ENTRY,
		FN_DISPLAY_VALUE_FN_ENTRY
	} fn_t;

	typedef struct packed {
		logic up;
		logic down;
		logic sel;
		logic ent;
	} keys_t;

	typedef struct packed {
		logic [4:0] index;
		logic [4:0] count;
		logic       show_pair;
		logic       fail;
		logic       last_was_remove;
		logic       at_prompt;
		logic       to_menu;
	} display_value_fn_t;
endpackage : lin_pkg

// *** core/lin_editor.sv ***
// break-point table editor and piecewise-linear evaluator
`include "lin_params.svh"

module lin_editor
	import lin_pkg::*;
#(
	parameter int MAX_PTS = `LIN_MAX_PTS,
	parameter int CW      = 16,
	parameter int DW      = 20
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire keys_t                i_keys,
	input  wire fn_t                  i_fn,
	input  wire logic                 i_fn_start,
	input  wire logic                 i_table_default_reset,
	input  wire logic [CW-1:0]        i_live_ua,
	output logic      [CW-1:0]        o_edit_val,
	output logic      [2:0]           o_digit,
	output logic                      o_editing,
	output display_value_fn_t                     o_display_value_fn,
	output logic signed [DW-1:0]      o_display_value
);
	initial begin
		if (MAX_PTS < `LIN_MIN_PTS || MAX_PTS > 31 || CW < 15 || DW < 8)
			$error("lin_editor: unsupported parameters");
	end

	localparam int IW = 5;

	// ==========================================================
	// key synchronisers and press edges
	keys_t k1_ff, k2_ff, k3_ff;
	always_ff @(posedge i_clk) begin
		k1_ff <= i_keys;
		k2_ff <= k1_ff;
		k3_ff <= k2_ff;
	end
	wire keys_t press = k2_ff & ~k3_ff;
	logic [CW-1:0] live1_ff, live_ff;
	always_ff @(posedge i_clk) begin
		live1_ff <= i_live_ua;
		live_ff  <= live1_ff;
	end

	// ==========================================================
	// table storage
	logic        [CW-1:0] cur_ff  [MAX_PTS];
	logic signed [DW-1:0] dsp_ff  [MAX_PTS];
	logic [IW-1:0] cnt_ff, sel_ff;
	logic [2:0]    digit_ff;
	logic          editing_ff, fail_ff, last_rm_ff, ent_once_ff, to_menu_ff;
	logic [CW-1:0] edit_ff;
	fn_t           fn_ff;

	wire [IW-1:0] max_idx  = IW'(MAX_PTS);
	wire [IW-1:0] last_idx = cnt_ff - 5'h01;
	wire          is_pair  = (fn_ff == FN_ADD) || (fn_ff == FN_REMOVE);
	wire          sel_up   = press.up && !editing_ff && sel_ff < last_idx;
	wire          sel_dn   = press.down && !editing_ff && sel_ff != 5'h00;
	wire          do_ins   = is_pair && fn_ff == FN_ADD && press.sel && cnt_ff < max_idx;
	wire          do_rm    = fn_ff == FN_REMOVE && press.sel && cnt_ff > 5'(`LIN_MIN_PTS);

	// candidate current and its neighbour check
	wire          cur_mode  = fn_ff == FN_CAPTURE || fn_ff == FN_CUR_ENTRY;
	wire [CW-1:0] cand_cur  = (fn_ff == FN_CAPTURE) ? live_ff : edit_ff;
	wire [CW-1:0] prev_cur  = (sel_ff == 5'h00) ? CW'(0) : cur_ff[sel_ff - 5'h01];
	wire [CW-1:0] cur_at_sel = cur_ff[sel_ff];
	wire [CW-1:0] next_cur  = (sel_ff == last_idx) ? {CW{1'b1}} : cur_ff[sel_ff + 5'h01];
	wire          in_range  = cand_cur >= CW'(`LIN_CUR_MIN_UA) && cand_cur <= CW'(`LIN_CUR_MAX_UA);
	wire          order_ok  = (sel_ff == 5'h00 || cand_cur > prev_cur) &&
	                          (sel_ff == last_idx || cand_cur < next_cur);
	wire          cur_ok    = in_range && order_ok;
	wire          cap_store = fn_ff == FN_CAPTURE && press.sel && !editing_ff;
	wire          ent_store = editing_ff && press.ent;
	wire          cur_store = (cap_store || (ent_store && fn_ff == FN_CUR_ENTRY)) && cur_ok;
	wire          cur_rej   = (cap_store || (ent_store && fn_ff == FN_CUR_ENTRY)) && !cur_ok;
	wire          dsp_store = ent_store && (fn_ff == FN_DISPLAY_VALUE_FN_ENTRY || fn_ff == FN_CAPTURE);

	// digit step of the edited value, in decimal weight
	function automatic logic [CW-1:0] pow10(input logic [2:0] d);
		case (d)
			3'h0:    pow10 = CW'(10000);
			3'h1:    pow10 = CW'(1000);
			3'h2:    pow10 = CW'(100);
			3'h3:    pow10 = CW'(10);
			default: pow10 = CW'(1);
		endcase
	endfunction : pow10
	wire [CW-1:0] step = pow10(digit_ff);

	// ==========================================================
	// editing state
	always_ff @(posedge i_clk) begin
		if (i_rst || i_fn_start) begin
			fn_ff       <= i_rst ? FN_ADD : i_fn;
			sel_ff      <= 5'h00;
			editing_ff  <= 1'b0;
			digit_ff    <= 3'h0;
			edit_ff     <= '0;
			fail_ff     <= 1'b0;
			ent_once_ff <= 1'b0;
			to_menu_ff  <= 1'b0;
			if (i_rst)
				last_rm_ff <= 1'b0;
		end else begin
			to_menu_ff <= 1'b0;
			if (press.ent && !editing_ff) begin
				ent_once_ff <= ~ent_once_ff;
				to_menu_ff  <= ent_once_ff;
				if (is_pair)
					last_rm_ff <= fn_ff == FN_REMOVE;
			end
			if (sel_up)
				sel_ff <= sel_ff + 5'h01;
			else if (sel_dn)
				sel_ff <= sel_ff - 5'h01;
			else if (do_rm && sel_ff == last_idx)
				sel_ff <= sel_ff - 5'h01;
			if (cur_rej)
				fail_ff <= 1'b1;
			else if (press.up || press.down || press.sel)
				fail_ff <= 1'b0;
			if (!editing_ff && press.sel && !is_pair &&
			    (fn_ff != FN_CAPTURE || cur_ok)) begin
				editing_ff  <= 1'b1;
				ent_once_ff <= 1'b0;
				digit_ff    <= 3'h0;
				edit_ff     <= (fn_ff == FN_CUR_ENTRY) ? cur_ff[sel_ff] : CW'(dsp_ff[sel_ff]);
			end else if (editing_ff) begin
				if (press.up)
					edit_ff <= edit_ff + step;
				else if (press.down && edit_ff >= step)
					edit_ff <= edit_ff - step;
				if (press.sel)
					digit_ff <= (digit_ff == 3'(`LIN_NUM_DIGITS - 1)) ? 3'h0 : digit_ff + 3'h1;
				if (press.ent)
					editing_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// table update: insert, remove, store
	always_ff @(posedge i_clk) begin
		if (i_rst || i_table_default_reset) begin
			cnt_ff <= 5'(`LIN_MIN_PTS);
			for (int i = 0; i < MAX_PTS; i++) begin
				cur_ff[i] <= (i == 0) ? CW'(`LIN_LOOP_LO_UA) : CW'(`LIN_LOOP_HI_UA);
				dsp_ff[i] <= (i == 0) ? DW'(`LIN_DEF_DISPLAY_VALUE_FN_LO) : DW'(`LIN_DEF_DISPLAY_VALUE_FN_HI);
			end
		end else if (do_ins) begin
			cnt_ff <= cnt_ff + 5'h01;
			for (int i = 1; i < MAX_PTS; i++) begin
				if (IW'(i) > sel_ff) begin
					cur_ff[i] <= cur_ff[i-1];
					dsp_ff[i] <= dsp_ff[i-1];
				end
			end
		end else if (do_rm) begin
			cnt_ff <= cnt_ff - 5'h01;
			for (int i = 0; i < MAX_PTS - 1; i++) begin
				if (IW'(i) >= sel_ff) begin
					cur_ff[i] <= cur_ff[i+1];
					dsp_ff[i] <= dsp_ff[i+1];
				end
			end
		end else begin
			if (cur_store && cur_mode)
				cur_ff[sel_ff] <= cand_cur;
			if (dsp_store)
				dsp_ff[sel_ff] <= DW'(signed'({1'b0, edit_ff}));
		end
	end

	// ==========================================================
	// piecewise-linear evaluation of the live current
	logic [IW-1:0] seg;
	always_comb begin
		seg = 5'h00;
		for (int i = 1; i < MAX_PTS - 1; i++)
			if (IW'(i) < last_idx && live_ff >= cur_ff[i])
				seg = IW'(i); // end segments extend outward
	end
	wire signed [CW:0]     x0  = signed'({1'b0, cur_ff[seg]});
	wire signed [CW:0]     x1  = signed'({1'b0, cur_ff[seg + 5'h01]});
	wire signed [CW:0]     xi  = signed'({1'b0, live_ff});
	wire signed [DW-1:0]   y0  = dsp_ff[seg];
	wire signed [DW-1:0]   y1  = dsp_ff[seg + 5'h01];
	wire signed [DW+CW+1:0] num = (y1 - y0) * (xi - x0);
	wire signed [CW:0]     dx  = (x1 == x0) ? (CW+1)'(1) : x1 - x0;
	wire signed [DW+CW+1:0] q  = num / dx;

	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_display_value <= '0;
		else
			o_display_value <= y0 + DW'(q);
	end

	// ==========================================================
	// operator-facing outputs
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_display_value_fn     <= '0;
			o_edit_val <= '0;
			o_digit    <= 3'h0;
			o_editing  <= 1'b0;
		end else begin
			o_display_value_fn.index           <= sel_ff;
			o_display_value_fn.count           <= last_idx; // shown total is the highest index
			o_display_value_fn.show_pair       <= !editing_ff;
			o_display_value_fn.fail            <= fail_ff | cur_rej;
			o_display_value_fn.last_was_remove <= last_rm_ff;
			o_display_value_fn.at_prompt       <= ent_once_ff;
			o_display_value_fn.to_menu         <= to_menu_ff;
			o_edit_val             <= edit_ff;
			o_digit                <= digit_ff;
			o_editing              <= editing_ff;
		end
	end

	// ==========================================================
	// checks
	property p_min_count;
		@(posedge i_clk) disable iff (i_rst) cnt_ff >= 5'(`LIN_MIN_PTS);
	endproperty
	a_min_count: assert property (p_min_count) else $error("table below two points");

	property p_ins_count;
		@(posedge i_clk) disable iff (i_rst || i_table_default_reset) do_ins |=> cnt_ff == $past(cnt_ff) + 5'h01;
	endproperty
	a_ins_count: assert property (p_ins_count) else $error("insert did not add one");

	property p_rm_count;
		@(posedge i_clk) disable iff (i_rst || i_table_default_reset) do_rm |=> cnt_ff == $past(cnt_ff) - 5'h01;
	endproperty
	a_rm_count: assert property (p_rm_count) else $error("remove did not drop one");

	property p_full;
		@(posedge i_clk) disable iff (i_rst) cnt_ff <= max_idx;
	endproperty
	a_full: assert property (p_full) else $error("table exceeds maximum");

	property p_reject_keeps;
		@(posedge i_clk) disable iff (i_rst || i_table_default_reset)
			cur_rej |=> cur_ff[$past(sel_ff)] == $past(cur_at_sel);
	endproperty
	a_reject_keeps: assert property (p_reject_keeps) else $error("rejected current stored");

	property p_fail_shown;
		@(posedge i_clk) disable iff (i_rst) cur_rej |=> o_display_value_fn.fail;
	endproperty
	a_fail_shown: assert property (p_fail_shown) else $error("fail not shown");

	property p_start_zero;
		@(posedge i_clk) disable iff (i_rst) i_fn_start |=> sel_ff == 5'h00 ##1 o_display_value_fn.index == 5'h00;
	endproperty
	a_start_zero: assert property (p_start_zero) else $error("function did not start at zero");

	property p_accept_range;
		@(posedge i_clk) disable iff (i_rst) cur_store |-> cand_cur > CW'(`LIN_CUR_MIN_UA - 1);
	endproperty
	a_accept_range: assert property (p_accept_range) else $error("current below range accepted");

	property p_ins_refused;
		@(posedge i_clk) disable iff (i_rst || i_table_default_reset)
			fn_ff == FN_ADD && press.sel && cnt_ff == max_idx |=> cnt_ff == max_idx;
	endproperty
	a_ins_refused: assert property (p_ins_refused) else $error("insert accepted on a full table");

	property p_rm_refused;
		@(posedge i_clk) disable iff (i_rst || i_table_default_reset)
			fn_ff == FN_REMOVE && press.sel && cnt_ff == 5'(`LIN_MIN_PTS) |=> cnt_ff == 5'(`LIN_MIN_PTS);
	endproperty
	a_rm_refused: assert property (p_rm_refused) else $error("remove went below two points");

	property p_display_value_fn_store;
		@(posedge i_clk) disable iff (i_rst || i_table_default_reset)
			dsp_store |=> dsp_ff[$past(sel_ff)][CW-1:0] == $past(edit_ff);
	endproperty
	a_display_value_fn_store: assert property (p_display_value_fn_store) else $error("typed display value not stored");
endmodule : lin_editor

// *** verification/lin_operator.sv ***
// front-panel operator model: buttons and live loop current
module lin_operator
	import lin_pkg::*;
(
	input  wire logic        i_clk,
	output keys_t            o_keys,
	output logic [15:0]      o_live_ua
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		o_keys    = '0;
		o_live_ua = 16'h2EE0;
	end

	// ==========================================================
	// one press, held past the two-stage synchroniser, then released
	task automatic press(input int k);
		@(negedge i_clk);
		o_keys[k] = 1'b1;
		repeat (5) @(negedge i_clk);
		o_keys[k] = 1'b0;
		repeat (6) @(negedge i_clk);
	endtask : press

	// the current is settled before any capturing press
	task automatic set_ua(input logic [15:0] ua);
		@(negedge i_clk);
		o_live_ua = ua;
		repeat (6) @(negedge i_clk);
	endtask : set_ua
endmodule : lin_operator

// *** verification/lin_editor_tb.sv ***
// self-checking bench for the lineariser break-point editor
module lin_editor_tb
	import lin_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [1:0]  kind;
		logic [19:0] exp;
	} note_t;

	localparam int K_UP  = 3;
	localparam int K_SEL = 1;
	localparam int K_ENT = 0;

	logic               i_clk;
	logic               i_rst;
	logic               i_fn_start;
	logic               i_table_default_reset;
	fn_t                i_fn;
	keys_t              keys;
	logic [15:0]        live_ua;
	display_value_fn_t              o_display_value_fn;
	logic signed [19:0] o_display_value;
	note_t              notes[$];
	int                 fail_count;
	int                 total_checks;
	int                 k;
	event               result_ready;

	lin_editor DUT (
		.i_clk(i_clk), .i_rst(i_rst), .i_keys(keys), .i_fn(i_fn), .i_fn_start(i_fn_start),
		.i_table_default_reset(i_table_default_reset), .i_live_ua(live_ua), .o_edit_val(),
		.o_digit(), .o_editing(), .o_display_value_fn(o_display_value_fn), .o_display_value(o_display_value)
	);

	lin_operator op (.i_clk(i_clk), .o_keys(keys), .o_live_ua(live_ua));

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// ==========================================================
	// comparison and bookkeeping
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic expect_val(input logic [1:0] kind, input logic [19:0] exp);
		notes.push_back('{kind, exp});
		-> result_ready;
		#1;
	endtask : expect_val

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	// ==========================================================
	// monitor: oldest note against the settled outputs
	initial begin
		note_t n;
		forever begin
			@(result_ready);
			while (notes.size() > 0) begin
				n = notes.pop_front();
				case (n.kind)
					2'h0: check({15'h0000, o_display_value_fn.count}, n.exp);
					2'h1: check({15'h0000, o_display_value_fn.index}, n.exp);
					2'h2: check(o_display_value, n.exp);
					default: check({18'h00000, o_display_value_fn.fail, o_display_value_fn.last_was_remove}, n.exp);
				endcase
			end
		end
	end

	task automatic start_fn(input fn_t f);
		i_fn       = f;
		i_fn_start = 1'b1;
		@(negedge i_clk);
		i_fn_start = 1'b0;
		repeat (3) @(negedge i_clk);
	endtask : start_fn

	task automatic table_reset();
		i_table_default_reset = 1'b1;
		@(negedge i_clk);
		i_table_default_reset = 1'b0;
		repeat (3) @(negedge i_clk);
	endtask : table_reset

	// ==========================================================
	// main sequence
	initial begin
		fail_count = 0;
		total_checks = 0;
		i_rst = 1'b1;
		i_fn = FN_ADD;
		i_fn_start = 1'b0;
		i_table_default_reset = 1'b0;
		k = $urandom(24866);
		repeat (2) @(negedge i_clk);
		i_rst = 1'b0;
		@(negedge i_clk);
		table_reset();
		start_fn(FN_ADD);
		expect_val(2'h1, 20'h00000);
		expect_val(2'h0, 20'h00001);
		op.press(K_UP);
		expect_val(2'h1, 20'h00001);
		// each insertion goes before the current top point
		for (int i = 3; i <= 17; i++) begin
			op.press(K_SEL);
			expect_val(2'h0, 20'(i - 1));
			expect_val(2'h1, 20'(i - 2));
			op.press(K_UP);
		end
		op.press(K_SEL);
		expect_val(2'h0, 20'h00010);
		op.press(K_ENT);
		expect_val(2'h3, 20'h00000);
		start_fn(FN_REMOVE);
		for (int i = 16; i >= 2; i--) begin
			op.press(K_SEL);
			expect_val(2'h0, 20'(i - 1));
		end
		op.press(K_SEL);
		expect_val(2'h0, 20'h00001);
		op.press(K_ENT);
		expect_val(2'h3, 20'h00001);
		// 160 uA steps give exact display values, one step below and up to six steps above the table too
		table_reset();
		for (int i = 0; i < 8; i++) begin
			k = int'($urandom_range(107)) - 1;
			op.set_ua(16'(16'h0FA0 + 16'h00A0 * k));
			expect_val(2'h2, 20'(k));
		end
		op.set_ua(16'h0F00);
		expect_val(2'h2, 20'hFFFFF);
		// point 0 below range, then point 1 not above point 0
		start_fn(FN_CAPTURE);
		expect_val(2'h1, 20'h00000);
		// the remove prompt stays the last one used, so its flag stays up here
		for (int j = 0; j < 2; j++) begin
			op.set_ua(j == 0 ? 16'h0ED7 : 16'h0FA0);
			op.press(K_SEL);
			expect_val(2'h3, 20'h00003);
			op.press(K_UP);
			expect_val(2'h3, 20'h00001);
		end
		op.set_ua(16'h2EE0);
		expect_val(2'h2, 20'h00032);
		// capture 12 mA at the top point, keep its display value of 100
		op.press(K_SEL);
		op.press(K_ENT);
		expect_val(2'h2, 20'h00064);
		// top point display typed as 1100 on the thousands digit
		start_fn(FN_DISPLAY_VALUE_FN_ENTRY);
		op.press(K_UP);
		op.press(K_SEL);
		op.press(K_SEL);
		op.press(K_UP);
		op.press(K_ENT);
		expect_val(2'h2, 20'h0044C);
		// point zero current typed as 4100 uA, read back at 8 mA
		op.set_ua(16'h1F40);
		start_fn(FN_CUR_ENTRY);
		op.press(K_SEL);
		op.press(K_SEL);
		op.press(K_SEL);
		op.press(K_UP);
		op.press(K_ENT);
		expect_val(2'h2, 20'h0021F);
		close_out();
	end

	// hang guard: a run that outlives this bound is a mismatch
	initial begin
		repeat (20000) @(posedge i_clk);
		fail_count++;
		close_out();
	end
endmodule : lin_editor_tb
